// [hdl/pid_supervisor.sv]
// pid_supervisor: feedback-loss, deviation and sleep/wake supervision
// assumes inputs synchronous to clock, apb slave with zero wait states
//
// Overview of operation
// - loss detection only on 4-20mA current input
// - warn after abnormal held for detection time
// - zero detection time disables loss detection
// - two-bit selector picks loss fault reaction
// - sustained deviation raises fault on output
// - deviation level and time limited, defaults
// - direction reversal only when enable set
// - sleep references in hertz or percent
// - compare command or feedback by selector
// - sleep below reference, wake above wake
// - clamp integral to wake limit after wake
// - no pid: hold sleep frequency, then sleep
// - pid: decelerate, sleep on timer expiry
// - pid: hold lower limit until timer expiry
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module pid_supervisor #(
	// clocks per tenth-second tick; a bench may shorten it
	parameter int unsigned TICK_CYCLES = pid_sup_pkg::TENTH_CYCLES
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// pid core and generator inputs
	input  wire logic [15:0] analog_current_input,
	input  wire logic        fb_abnormal,
	input  wire logic [15:0] pid_reference,
	input  wire logic [15:0] pid_feedback,
	input  wire logic [15:0] pid_cmd_freq,
	input  wire logic        pid_cmd_reverse,
	input  wire logic [15:0] out_freq,
	// drive controls
	output logic [15:0]      freq_target,
	output logic             run_reverse,
	output logic             ramp_stop,
	output logic             coast_stop,
	output logic             hold_freq,
	output logic             fb_loss_warn,
	output logic             multi_function_output,
	output logic             sleeping,
	output logic [15:0]      integral_limit,
	output logic             integral_clamp,
	output logic             irq
);
	// prescaler state
	logic [$clog2(TICK_CYCLES)-1:0] pre_reg;
	pid_tick_if tk_src ();

	typedef struct packed {
		logic [31:0]                 ctrl;
		logic [15:0]                 fbtime;
		logic [15:0]                 devlvl;
		logic [15:0]                 devtime;
		logic [15:0]                 sleep_ref;
		logic [15:0]                 wake_ref;
		logic [15:0]                 stime;
		logic [15:0]                 lower_lim;
		logic [15:0]                 min_out;
		logic [15:0]                 wake_int;
		logic [pid_sup_pkg::IRQ_W-1:0] ist;
		logic [pid_sup_pkg::IRQ_W-1:0] imask;
		pid_sup_pkg::sleep_st_t      sst;
		logic                        loss;
		logic                        deverr;
		logic                        clamp;
		logic                        rev;
		logic [15:0]                 held;
		logic [31:0]                 rdata;
	} st_t;
	st_t st_reg;
	st_t st_next;

	// clamp a written value into its legal range
	function automatic logic [15:0] clip(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		clip = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// absolute difference of two unsigned words
	function automatic logic [15:0] absdiff(input logic [15:0] a,
		input logic [15:0] b);
		absdiff = (a > b) ? (a - b) : (b - a);
	endfunction

	// control fields
	logic                   aci_420;
	logic                   pid_on;
	logic                   src_fb;
	logic                   dir_en;
	pid_sup_pkg::react_t    react;
	logic [15:0]            watched;
	logic                   loss_cond;
	logic                   dev_cond;
	logic                   below;
	logic                   above;
	logic                   loss_exp;
	logic                   dev_exp;
	logic                   sleep_exp;
	logic                   sleep_cond;
	logic [15:0]            floor_f;
	logic                   wr;
	logic                   rd;

	assign aci_420 = st_reg.ctrl[pid_sup_pkg::CTRL_ACI_420];
	assign pid_on  = st_reg.ctrl[pid_sup_pkg::CTRL_PID_ON];
	assign src_fb  = st_reg.ctrl[pid_sup_pkg::CTRL_SLEEP_SRC];
	assign dir_en  = st_reg.ctrl[pid_sup_pkg::CTRL_DIR_EN];
	assign react   = pid_sup_pkg::react_t'(
		st_reg.ctrl[pid_sup_pkg::CTRL_REACT_LSB +: 2]);

	// loss watched only on 4-20mA input with a nonzero time
	assign loss_cond = aci_420 && (st_reg.fbtime != pid_sup_pkg::RST_ZERO16)
		&& fb_abnormal;
	// deviation beyond level; level in tenths, compared in hundredths
	assign dev_cond = pid_on && (absdiff(pid_reference, pid_feedback) >
		16'(st_reg.devlvl * 16'd10));
	// compared signal follows the sleep source selector
	assign watched = src_fb ? pid_feedback : pid_cmd_freq;
	assign below = watched < st_reg.sleep_ref;
	assign above = watched > st_reg.wake_ref;
	// floor is lower limit, or minimum output when no limit set
	assign floor_f = (st_reg.lower_lim != pid_sup_pkg::RST_ZERO16) ?
		st_reg.lower_lim : st_reg.min_out;
	assign sleep_cond = (st_reg.sst != pid_sup_pkg::S_RUN) &&
		(st_reg.sst != pid_sup_pkg::S_SLEEP);
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;

	// tenth-second prescaler feeding every timer
	always_ff @(posedge clock) begin
		if (sys_rst)
			pre_reg <= '0;
		else if (tk_src.tick)
			pre_reg <= '0;
		else
			pre_reg <= pre_reg + 1'b1;
	end
	assign tk_src.tick = (pre_reg ==
		($bits(pre_reg))'(TICK_CYCLES - 1));

	// feedback-loss timer
	pid_hold_timer #(.W(16)) u_loss (
		.clock   (clock),
		.sys_rst (sys_rst),
		.tk      (tk_src),
		.cond    (loss_cond),
		.limit   (st_reg.fbtime),
		.expired (loss_exp)
	);

	// deviation timer; strictly longer than the set time
	pid_hold_timer #(.W(16)) u_dev (
		.clock   (clock),
		.sys_rst (sys_rst),
		.tk      (tk_src),
		.cond    (dev_cond),
		.limit   (16'(st_reg.devtime + 1'b1)),
		.expired (dev_exp)
	);

	// sleep timer, tenths of a second
	pid_hold_timer #(.W(16)) u_sleep (
		.clock   (clock),
		.sys_rst (sys_rst),
		.tk      (tk_src),
		.cond    (sleep_cond),
		.limit   (st_reg.stime),
		.expired (sleep_exp)
	);

	// register file, fault flags and sleep sequencer
	always_comb begin
		// read data holds from the access phase until the next read
		st_next = st_reg;
		// apb writes with range clamping
		if (wr) begin
			unique case (paddr)
			pid_sup_pkg::OFS_CTRL:   st_next.ctrl = {26'h0, pwdata[5:0]};
			pid_sup_pkg::OFS_FBTIME: st_next.fbtime = clip(pwdata[15:0],
				pid_sup_pkg::RST_ZERO16, pid_sup_pkg::FBTIME_MAX);
			pid_sup_pkg::OFS_DEV: begin
				st_next.devlvl = clip(pwdata[15:0],
					pid_sup_pkg::DEVLVL_MIN, pid_sup_pkg::DEVLVL_MAX);
				st_next.devtime = clip(pwdata[31:16],
					pid_sup_pkg::DEVTIME_MIN, pid_sup_pkg::DEVTIME_MAX);
			end
			pid_sup_pkg::OFS_SLEEP: st_next.sleep_ref = clip(pwdata[15:0],
				pid_sup_pkg::RST_ZERO16, pwdata[16] ? pid_sup_pkg::PCT_MAX :
				pid_sup_pkg::HZ_MAX);
			pid_sup_pkg::OFS_WAKE: st_next.wake_ref = clip(pwdata[15:0],
				pid_sup_pkg::RST_ZERO16, pwdata[16] ? pid_sup_pkg::PCT_MAX :
				pid_sup_pkg::HZ_MAX);
			pid_sup_pkg::OFS_STIME: begin
				st_next.stime = pwdata[15:0];
				st_next.wake_int = clip(pwdata[31:16],
					pid_sup_pkg::RST_ZERO16, pid_sup_pkg::WINT_MAX);
			end
			pid_sup_pkg::OFS_LIMITS: begin
				st_next.lower_lim = pwdata[15:0];
				st_next.min_out = pwdata[31:16];
			end
			pid_sup_pkg::OFS_IRQ_STAT:
				st_next.ist = st_reg.ist & ~pwdata[pid_sup_pkg::IRQ_W-1:0];
			pid_sup_pkg::OFS_IRQ_MASK:
				st_next.imask = pwdata[pid_sup_pkg::IRQ_W-1:0];
			default: ;
			endcase
		end
		// read data captured in setup, presented in access
		if (rd) begin
			unique case (paddr)
			pid_sup_pkg::OFS_CTRL:   st_next.rdata = st_reg.ctrl;
			pid_sup_pkg::OFS_FBTIME: st_next.rdata = {16'h0, st_reg.fbtime};
			pid_sup_pkg::OFS_DEV: st_next.rdata = {st_reg.devtime, st_reg.devlvl};
			pid_sup_pkg::OFS_SLEEP: st_next.rdata = {16'h0, st_reg.sleep_ref};
			pid_sup_pkg::OFS_WAKE:  st_next.rdata = {16'h0, st_reg.wake_ref};
			pid_sup_pkg::OFS_STIME: st_next.rdata = {st_reg.wake_int,
				st_reg.stime};
			pid_sup_pkg::OFS_LIMITS: st_next.rdata = {st_reg.min_out,
				st_reg.lower_lim};
			pid_sup_pkg::OFS_STATUS: st_next.rdata = {24'h0, st_reg.sst,
				st_reg.clamp, st_reg.rev, st_reg.deverr, st_reg.loss};
			pid_sup_pkg::OFS_IRQ_STAT: st_next.rdata = {28'h0, st_reg.ist};
			pid_sup_pkg::OFS_IRQ_MASK: st_next.rdata = {28'h0, st_reg.imask};
			default: st_next.rdata = 32'h0000_0000;
			endcase
		end
		// fault levels follow their timers
		st_next.loss = loss_exp;
		st_next.deverr = dev_exp;
		// reversal passes only with the enable set
		st_next.rev = dir_en ? pid_cmd_reverse : 1'b0;
		if (!(react == pid_sup_pkg::REACT_HOLD && loss_exp))
			st_next.held = out_freq;
		// sleep sequencer
		unique case (st_reg.sst)
		pid_sup_pkg::S_RUN: begin
			if (below) begin
				st_next.clamp = 1'b0;
				st_next.sst = pid_on ? pid_sup_pkg::S_DECEL :
					pid_sup_pkg::S_HOLD;
			end
		end
		pid_sup_pkg::S_HOLD: begin
			if (!below)
				st_next.sst = pid_sup_pkg::S_RUN;
			else if (sleep_exp)
				st_next.sst = pid_sup_pkg::S_SLEEP;
		end
		pid_sup_pkg::S_DECEL: begin
			if (sleep_exp)
				st_next.sst = pid_sup_pkg::S_SLEEP;
		end
		pid_sup_pkg::S_SLEEP: begin
			if (above) begin
				st_next.sst = pid_sup_pkg::S_RUN;
				st_next.clamp = 1'b1;
			end
		end
		default: st_next.sst = pid_sup_pkg::S_RUN;
		endcase
		// clamp releases once the watched signal falls to or below the wake reference
		if (st_reg.clamp && st_reg.sst == pid_sup_pkg::S_RUN &&
			!above)
			st_next.clamp = 1'b0;
		// sticky events; a set beats a clear in the same cycle
		if (loss_exp && !st_reg.loss)
			st_next.ist[pid_sup_pkg::IRQ_FBLOSS] = 1'b1;
		if (dev_exp && !st_reg.deverr)
			st_next.ist[pid_sup_pkg::IRQ_DEVERR] = 1'b1;
		if (st_next.sst == pid_sup_pkg::S_SLEEP &&
			st_reg.sst != pid_sup_pkg::S_SLEEP)
			st_next.ist[pid_sup_pkg::IRQ_SLEEP] = 1'b1;
		if (st_reg.sst == pid_sup_pkg::S_SLEEP &&
			st_next.sst == pid_sup_pkg::S_RUN)
			st_next.ist[pid_sup_pkg::IRQ_WAKE] = 1'b1;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_reg           <= '0;
			st_reg.ctrl      <= pid_sup_pkg::RST_CTRL;
			st_reg.devlvl    <= pid_sup_pkg::RST_DEVLVL;
			st_reg.devtime   <= pid_sup_pkg::RST_DEVTIME;
			st_reg.wake_int  <= pid_sup_pkg::RST_WAKEINT;
			st_reg.sst       <= pid_sup_pkg::S_RUN;
		end else begin
			st_reg <= st_next;
		end
	end

	// frequency target per sequencer state and loss reaction
	always_comb begin
		unique case (st_reg.sst)
		pid_sup_pkg::S_HOLD:  freq_target = st_reg.sleep_ref;
		pid_sup_pkg::S_DECEL: freq_target = sleep_exp ? 16'h0000 :
			floor_f;
		pid_sup_pkg::S_SLEEP: freq_target = 16'h0000;
		default: freq_target = (st_reg.loss &&
			react == pid_sup_pkg::REACT_HOLD) ? st_reg.held :
			pid_cmd_freq;
		endcase
	end

	// outputs
	assign ramp_stop  = st_reg.loss && react == pid_sup_pkg::REACT_RAMP;
	assign coast_stop = st_reg.loss && react == pid_sup_pkg::REACT_COAST;
	assign hold_freq  = st_reg.loss && react == pid_sup_pkg::REACT_HOLD;
	assign fb_loss_warn = st_reg.loss;
	assign multi_function_output = st_reg.deverr;
	assign run_reverse = st_reg.rev;
	assign sleeping = st_reg.sst == pid_sup_pkg::S_SLEEP;
	assign integral_limit = st_reg.wake_int;
	assign integral_clamp = st_reg.clamp;
	assign irq = |(st_reg.ist & st_reg.imask);
	assign prdata = st_reg.rdata;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
endmodule

// [hdl/pid_sup_pkg.sv]
// pid_sup_pkg: shared constants and types for the pid supervisor block
// assumes a 10 MHz control clock and a 32-bit apb register bus
package pid_sup_pkg;
	// clock rate and time units
	localparam int unsigned CLK_HZ         = 10_000_000;
	localparam int unsigned TENTH_S_NS     = 100_000_000;
	localparam int unsigned CLK_NS         = 1_000_000_000 / CLK_HZ;
	// cycles in one tenth of a second, the unit of all timer settings
	localparam int unsigned TENTH_CYCLES   = TENTH_S_NS / CLK_NS;

	// register byte offsets
	localparam logic [11:0] OFS_CTRL     = 12'h000;
	localparam logic [11:0] OFS_FBTIME   = 12'h004;
	localparam logic [11:0] OFS_DEV      = 12'h008;
	localparam logic [11:0] OFS_SLEEP    = 12'h00C;
	localparam logic [11:0] OFS_WAKE     = 12'h010;
	localparam logic [11:0] OFS_STIME    = 12'h014;
	localparam logic [11:0] OFS_LIMITS   = 12'h018;
	localparam logic [11:0] OFS_STATUS   = 12'h01C;
	localparam logic [11:0] OFS_IRQ_STAT = 12'h020;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h024;

	// ctrl field positions
	localparam int CTRL_REACT_LSB = 0;
	localparam int CTRL_DIR_EN    = 2;
	localparam int CTRL_SLEEP_SRC = 3;
	localparam int CTRL_PID_ON    = 4;
	localparam int CTRL_ACI_420   = 5;

	// reset values (tenths of s, tenths of %, hundredths)
	localparam logic [31:0] RST_CTRL    = 32'h0000_0000;
	localparam logic [15:0] RST_FBTIME  = 16'h0000;
	localparam logic [15:0] RST_DEVLVL  = 16'h0064;
	localparam logic [15:0] RST_DEVTIME = 16'h0032;
	localparam logic [15:0] RST_WAKEINT = 16'h01F4;
	localparam logic [15:0] RST_ZERO16  = 16'h0000;
	localparam logic [15:0] DEVLVL_MIN  = 16'h000A;
	localparam logic [15:0] DEVLVL_MAX  = 16'h01F4;
	localparam logic [15:0] DEVTIME_MIN = 16'h0001;
	localparam logic [15:0] DEVTIME_MAX = 16'h0BB8;
	localparam logic [15:0] FBTIME_MAX  = 16'h8CA0;
	localparam logic [15:0] HZ_MAX      = 16'hEA60;
	localparam logic [15:0] PCT_MAX     = 16'h4E20;
	localparam logic [15:0] WINT_MAX    = 16'h07D0;

	// interrupt status bit positions
	localparam int IRQ_FBLOSS = 0;
	localparam int IRQ_DEVERR = 1;
	localparam int IRQ_SLEEP  = 2;
	localparam int IRQ_WAKE   = 3;
	localparam int IRQ_W      = 4;

	// fault reaction codes
	typedef enum logic [1:0] {
		REACT_RUN  = 2'h0,
		REACT_RAMP = 2'h1,
		REACT_COAST = 2'h2,
		REACT_HOLD = 2'h3
	} react_t;

	// sleep sequencer states, one-hot
	typedef enum logic [3:0] {
		S_RUN   = 4'b0001,
		S_HOLD  = 4'b0010,
		S_DECEL = 4'b0100,
		S_SLEEP = 4'b1000
	} sleep_st_t;
endpackage

// [hdl/pid_tick_if.sv]
// pid_tick_if: tenth-second tick carried from the prescaler to the timers
// assumes one clock domain; driver owns tick
`timescale 1ns/1ps
interface pid_tick_if;
	logic tick; // one-cycle pulse every tenth of a second
	modport src (output tick);
	modport dst (input tick);
endinterface

// [hdl/pid_hold_timer.sv]
// pid_hold_timer: counts tenth-second ticks while a condition holds
// assumes tick arrives from the shared prescaler
`timescale 1ns/1ps
module pid_hold_timer #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         sys_rst,
	// tick input
	pid_tick_if.dst           tk,
	// condition and limit
	input  wire logic         cond,
	input  wire logic [W-1:0] limit,
	// result, level while condition held past the limit
	output logic              expired
);
	typedef struct packed {
		logic [W-1:0] cnt; // elapsed tenths
		logic         exp; // limit reached
	} st_t;
	st_t st_reg;
	st_t st_next;

	// counting restarts from zero whenever the condition drops
	always_comb begin
		st_next = st_reg;
		if (!cond) begin
			st_next.cnt = '0;
			st_next.exp = 1'b0;
		end else begin
			if (st_reg.cnt >= limit)
				st_next.exp = 1'b1;
			else if (tk.tick)
				st_next.cnt = st_reg.cnt + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign expired = st_reg.exp;
endmodule

// [testbench/pid_sup_assertions.sv]
// pid_sup_assertions: port-level checks of the pid supervisor
// assumes it is bound onto pid_supervisor, one clock domain
`timescale 1ns/1ps
module pid_sup_assertions (
	// clock and reset
	input wire logic        clock,
	input wire logic        sys_rst,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// core side
	input wire logic        fb_abnormal,
	input wire logic        pid_cmd_reverse,
	input wire logic [15:0] freq_target,
	input wire logic        run_reverse,
	input wire logic        ramp_stop,
	input wire logic        coast_stop,
	input wire logic        hold_freq,
	input wire logic        fb_loss_warn,
	input wire logic        sleeping,
	input wire logic [15:0] integral_limit,
	input wire logic        integral_clamp
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// write to the word holding the wake integral limit
	wire stime_wr = psel && penable && pwrite &&
		paddr == pid_sup_pkg::OFS_STIME;
	// drive leaves sleep
	sequence s_wake;
		$fell(sleeping);
	endsequence
	// some loss reaction is active
	sequence s_react;
		ramp_stop || coast_stop || hold_freq;
	endsequence
	a_ready_always: assert property (pready)
		else $error("pready low");
	a_no_slverr: assert property (!pslverr)
		else $error("pslverr high");
	a_prdata_holds: assert property (psel && penable |=> $stable(prdata))
		else $error("read data moved after access");
	a_ilimit_written: assert property (!stime_wr |=> $stable(integral_limit))
		else $error("integral limit moved without write");
	a_wake_clamp: assert property (s_wake |-> integral_clamp)
		else $error("no integral clamp on wake");
	a_sleep_zero: assert property (sleeping |-> freq_target == 16'h0000)
		else $error("sleeping with nonzero target");
	a_reverse_cause: assert property (run_reverse |-> $past(pid_cmd_reverse))
		else $error("reverse without pid request");
	a_react_onehot: assert property ($onehot0({ramp_stop, coast_stop, hold_freq}))
		else $error("several loss reactions at once");
	a_react_loss: assert property (s_react |-> fb_loss_warn)
		else $error("loss reaction without warning");
	a_loss_cause: assert property ($rose(fb_loss_warn) |-> $past(fb_abnormal))
		else $error("loss warning without abnormal feedback");
endmodule

bind pid_supervisor pid_sup_assertions chk_u (.*);

// [testbench/drive_model.sv]
// drive_model: output frequency generator facing the supervisor
// assumes it follows freq_target, fast or one step in four cycles
`timescale 1ns/1ps
module drive_model (
	// clock and reset
	input wire logic        clock,
	input wire logic        sys_rst,
	// command and bench control
	input wire logic [15:0] freq_target,
	input wire logic        slow,
	// actual output frequency
	output logic     [15:0] out_freq
);
	logic [1:0] div; // step divider for the slow ramp
	// ramp toward the target in fixed steps, never overshooting
	always @(posedge clock) begin
		if (sys_rst) begin
			out_freq <= 16'h0000;
			div <= 2'h0;
		end else begin
			div <= div + 2'h1;
			if (!slow || div == 2'h0) begin
				if (freq_target > out_freq + 16'h0100) begin
					out_freq <= out_freq + 16'h0100;
				end else if (out_freq > freq_target + 16'h0100) begin
					out_freq <= out_freq - 16'h0100;
				end else begin
					out_freq <= freq_target;
				end
			end
		end
	end
endmodule

// [testbench/testbench.sv]
// testbench: self-checking bench of the pid supervisor
// assumes apb with pready, drive_model on the output side
`timescale 1ns/1ps
module testbench;
	// clock, reset and apb master
	logic        clock = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	// core side stimulus
	logic [15:0] analog_current_input = 16'h0000;
	logic        fb_abnormal = 1'b0;
	logic [15:0] pid_reference = 16'h1000;
	logic [15:0] pid_feedback = 16'h3000;
	logic [15:0] pid_cmd_freq = 16'h3000;
	logic        pid_cmd_reverse = 1'b0;
	logic        slow = 1'b0;
	// design outputs
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] out_freq;
	logic [15:0] freq_target;
	logic        run_reverse;
	logic        ramp_stop;
	logic        coast_stop;
	logic        hold_freq;
	logic        fb_loss_warn;
	logic        multi_function_output;
	logic        sleeping;
	logic [15:0] integral_limit;
	logic        integral_clamp;
	logic        irq;
	// bookkeeping
	int          n_fail = 0;
	int          num_checks = 0;
	logic [31:0] rd;

	// short tick so that the timers expire within the run
	pid_supervisor #(.TICK_CYCLES(10)) dut_u (.*);
	drive_model model_u (.*);

	// free-running clock
	always #50 clock = ~clock;

	// compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		if (n >= 50) n_fail++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdw(input logic [11:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask
	// let n edges pass, then settle
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// bounded wait for a sleep level
	task automatic wait_sleep(input logic want);
		int n;
		n = 0;
		while (sleeping !== want && n < 3000) begin
			cyc(1);
			n++;
		end
		chk({31'h0, sleeping}, {31'h0, want});
	endtask

	// reset values of every word, plus an unmapped one
	task automatic t_regs;
		logic [11:0] ofs [11] = '{pid_sup_pkg::OFS_CTRL,
			pid_sup_pkg::OFS_FBTIME, pid_sup_pkg::OFS_DEV,
			pid_sup_pkg::OFS_SLEEP, pid_sup_pkg::OFS_WAKE,
			pid_sup_pkg::OFS_STIME, pid_sup_pkg::OFS_LIMITS,
			pid_sup_pkg::OFS_STATUS, pid_sup_pkg::OFS_IRQ_STAT,
			pid_sup_pkg::OFS_IRQ_MASK, 12'h030};
		logic [31:0] exp [11] = '{pid_sup_pkg::RST_CTRL, 32'h0000_0000,
			{pid_sup_pkg::RST_DEVTIME, pid_sup_pkg::RST_DEVLVL},
			32'h0000_0000, 32'h0000_0000,
			{pid_sup_pkg::RST_WAKEINT, pid_sup_pkg::RST_ZERO16},
			32'h0000_0000, 32'h0000_0010, 32'h0000_0000,
			32'h0000_0000, 32'h0000_0000};
		for (int i = 0; i < 11; i++) begin
			rdw(ofs[i]);
			chk(rd, exp[i]);
		end
		chk({16'h0, integral_limit}, {16'h0, pid_sup_pkg::RST_WAKEINT});
	endtask

	// out-of-range writes are clamped, read-only and unmapped ignored
	task automatic t_clamp;
		wr(pid_sup_pkg::OFS_DEV, 32'h0000_0000);
		rdw(pid_sup_pkg::OFS_DEV);
		chk(rd, {pid_sup_pkg::DEVTIME_MIN, pid_sup_pkg::DEVLVL_MIN});
		wr(pid_sup_pkg::OFS_DEV, 32'hFFFF_FFFF);
		rdw(pid_sup_pkg::OFS_DEV);
		chk(rd, {pid_sup_pkg::DEVTIME_MAX, pid_sup_pkg::DEVLVL_MAX});
		wr(pid_sup_pkg::OFS_FBTIME, 32'h0000_FFFF);
		rdw(pid_sup_pkg::OFS_FBTIME);
		chk(rd, {16'h0, pid_sup_pkg::FBTIME_MAX});
		// command above any sleep reference, so no sleep starts here
		@(posedge clock) pid_cmd_freq <= 16'hFFFF;
		wr(pid_sup_pkg::OFS_SLEEP, 32'h0000_FFFF);
		rdw(pid_sup_pkg::OFS_SLEEP);
		chk({16'h0, rd[15:0]}, {16'h0, pid_sup_pkg::HZ_MAX});
		wr(pid_sup_pkg::OFS_SLEEP, 32'h0001_FFFF);
		rdw(pid_sup_pkg::OFS_SLEEP);
		chk({16'h0, rd[15:0]}, {16'h0, pid_sup_pkg::PCT_MAX});
		wr(pid_sup_pkg::OFS_STIME, 32'hFFFF_0000);
		cyc(1);
		chk({16'h0, integral_limit}, {16'h0, pid_sup_pkg::WINT_MAX});
		wr(12'h030, 32'hFFFF_FFFF);
		rdw(12'h030);
		chk(rd, 32'h0000_0000);
		wr(pid_sup_pkg::OFS_STATUS, 32'hFFFF_FFFF);
		rdw(pid_sup_pkg::OFS_STATUS);
		chk(rd, 32'h0000_0010);
	endtask

	// direction change by the pid only when enabled
	task automatic t_dir;
		wr(pid_sup_pkg::OFS_CTRL, 32'h0000_0000);
		@(posedge clock) pid_cmd_reverse <= 1'b1;
		cyc(4);
		chk({31'h0, run_reverse}, 32'h0000_0000);
		wr(pid_sup_pkg::OFS_CTRL, 32'h0000_0004);
		cyc(4);
		chk({31'h0, run_reverse}, 32'h0000_0001);
		@(posedge clock) pid_cmd_reverse <= 1'b0;
		cyc(4);
		chk({31'h0, run_reverse}, 32'h0000_0000);
	endtask

	// loss detection off with zero time or outside current mode
	task automatic t_loss;
		wr(pid_sup_pkg::OFS_FBTIME, 32'h0000_0000);
		@(posedge clock) fb_abnormal <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			wr(pid_sup_pkg::OFS_CTRL, 32'h0000_0020 | c);
			cyc(20);
			chk({28'h0, fb_loss_warn, ramp_stop, coast_stop, hold_freq},
				32'h0000_0000);
		end
		wr(pid_sup_pkg::OFS_FBTIME, 32'h0000_0001);
		wr(pid_sup_pkg::OFS_CTRL, 32'h0000_0001);
		cyc(20);
		chk({31'h0, fb_loss_warn}, 32'h0000_0000);
		@(posedge clock) fb_abnormal <= 1'b0;
	endtask

	// loss reactions, deviation fault, restart on recovery, events
	task automatic t_fault;
		logic [3:0] rx [4] = '{4'h8, 4'hC, 4'hA, 4'h9};
		wr(pid_sup_pkg::OFS_FBTIME, 32'h0000_0002);
		for (int c = 0; c < 4; c++) begin
			wr(pid_sup_pkg::OFS_CTRL, 32'h0000_0020 | c);
			@(posedge clock) fb_abnormal <= 1'b1;
			cyc(5);
			chk({31'h0, fb_loss_warn}, 32'h0000_0000);
			cyc(30);
			chk({28'h0, fb_loss_warn, ramp_stop, coast_stop, hold_freq},
				{28'h0, rx[c]});
			@(posedge clock) fb_abnormal <= 1'b0;
			cyc(3);
			chk({31'h0, fb_loss_warn}, 32'h0000_0000);
		end
		wr(pid_sup_pkg::OFS_DEV, 32'h0001_000A);
		@(posedge clock) pid_feedback <= 16'h1000;
		wr(pid_sup_pkg::OFS_CTRL, 32'h0000_0010);
		@(posedge clock) pid_feedback <= 16'h1200;
		cyc(5);
		chk({31'h0, multi_function_output}, 32'h0000_0000);
		cyc(40);
		chk({31'h0, multi_function_output}, 32'h0000_0001);
		@(posedge clock) pid_feedback <= 16'h1050;
		cyc(3);
		chk({31'h0, multi_function_output}, 32'h0000_0000);
		rdw(pid_sup_pkg::OFS_IRQ_STAT);
		chk(rd, 32'h0000_0003);
		wr(pid_sup_pkg::OFS_IRQ_STAT, 32'h0000_000F);
	endtask

	// sleep on command, interrupt set and cleared, wake, then interrupt masked
	task automatic t_sleep;
		wr(pid_sup_pkg::OFS_CTRL, 32'h0000_0000);
		wr(pid_sup_pkg::OFS_SLEEP, 32'h0000_1000);
		wr(pid_sup_pkg::OFS_WAKE, 32'h0000_2000);
		wr(pid_sup_pkg::OFS_STIME, {pid_sup_pkg::RST_WAKEINT, 16'h0000});
		wr(pid_sup_pkg::OFS_IRQ_MASK, 32'h0000_000C);
		@(posedge clock) pid_cmd_freq <= 16'h0800;
		wait_sleep(1'b1);
		chk({16'h0, freq_target}, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0001);
		rdw(pid_sup_pkg::OFS_STATUS);
		chk({28'h0, rd[7:4]}, {28'h0, pid_sup_pkg::S_SLEEP});
		wr(pid_sup_pkg::OFS_IRQ_STAT, 32'h0000_0004);
		cyc(2);
		chk({31'h0, irq}, 32'h0000_0000);
		@(posedge clock) pid_cmd_freq <= 16'h1800;
		cyc(20);
		chk({31'h0, sleeping}, 32'h0000_0001);
		@(posedge clock) pid_cmd_freq <= 16'h2100;
		wait_sleep(1'b0);
		chk({31'h0, integral_clamp}, 32'h0000_0001);
		chk({31'h0, irq}, 32'h0000_0001);
		rdw(pid_sup_pkg::OFS_IRQ_STAT);
		chk(rd, 32'h0000_0008);
		wr(pid_sup_pkg::OFS_IRQ_MASK, 32'h0000_0000);
		cyc(2);
		chk({31'h0, irq}, 32'h0000_0000);
		wr(pid_sup_pkg::OFS_IRQ_STAT, 32'h0000_0008);
	endtask

	// with pid on, feedback is watched and the drive ramps down slowly
	task automatic t_src;
		wr(pid_sup_pkg::OFS_CTRL, 32'h0000_0018);
		@(posedge clock) pid_cmd_freq <= 16'h0800;
		cyc(20);
		chk({31'h0, sleeping}, 32'h0000_0000);
		@(posedge clock) slow <= 1'b1;
		pid_feedback <= 16'h0800;
		wait_sleep(1'b1);
		@(posedge clock) pid_feedback <= 16'h2100;
		wait_sleep(1'b0);
	endtask

	// verdict and end of run
	task automatic report_and_stop;
		if (n_fail == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		t_regs();
		t_clamp();
		t_dir();
		t_loss();
		t_fault();
		t_sleep();
		t_src();
		report_and_stop();
	end

	// watchdog against a hang
	initial begin
		#(100 * 60000);
		n_fail++;
		report_and_stop();
	end
endmodule
